// *** verilog/emx_mux_if.sv ***
`timescale 1ns/1ps
module emx_mux_if
  import emx_pkg::*;
#(
  parameter int AW = emx_pkg::ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [emx_pkg::CFG_W-1:0] ext_mem_config_reg,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [emx_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [emx_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe,
  output logic [AW-9:0] addr_hi,
  output logic [7:0] addr_lo,
  output logic ale,
  output logic rd_n,
  output logic wr_n
);
  import emx_pkg::*;

  // ------------------------------------------------------------
  // State and capture registers
  // ------------------------------------------------------------
  emx_state_t st_r, st_nxt;
  logic wr_r, wr_nxt;
  logic muxed_r, muxed_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic ld;
  logic [3:0] ld_val;
  logic tmr_zero;
  logic mux_mode_select_bit;
  logic [7:0] ad_out_r, ad_out_nxt;
  logic [7:0] addr_lo_r, addr_lo_nxt;

  assign mux_mode_select_bit = ext_mem_config_reg[MUX_MODE_BIT_POS];

  emx_cnt #(.W(4)) u_tmr (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(ld),
    .load_val(ld_val),
    .zero(tmr_zero)
  );

  assign req_ready = (st_r == EMX_IDLE);

  always_comb begin
    st_nxt = st_r;
    wr_nxt = wr_r;
    muxed_nxt = muxed_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    ld = 1'b0;
    ld_val = 4'h0;
    case (st_r)
      EMX_IDLE: begin
        if (req_valid) begin
          wr_nxt = req_write;
          addr_nxt = req_addr;
          wd_nxt = req_wdata;
          muxed_nxt = ~mux_mode_select_bit;
          ld = 1'b1;
          ld_val = 4'(ALE_CYC - 1);
          st_nxt = ~mux_mode_select_bit ? EMX_ADDR : EMX_SETUP;
        end
      end
      EMX_ADDR: begin
        if (tmr_zero) begin
          st_nxt = EMX_SETUP; // ALE falls here
        end
      end
      EMX_SETUP: begin
        ld = 1'b1;
        ld_val = 4'(STB_CYC - 1);
        st_nxt = EMX_STB;
      end
      EMX_STB: begin
        if (tmr_zero) begin
          if (!wr_r) begin
            rd_nxt = ad_in;
          end
          st_nxt = EMX_DONE;
        end
      end
      EMX_DONE: begin
        st_nxt = EMX_IDLE;
      end
      default: begin
        st_nxt = EMX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= EMX_IDLE;
      wr_r <= 1'b0;
      muxed_r <= 1'b0;
      addr_r <= '0;
      wd_r <= DATA_RESET;
      rd_r <= DATA_RESET;
    end else begin
      st_r <= st_nxt;
      wr_r <= wr_nxt;
      muxed_r <= muxed_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Strobes decode registered state only, so no glitches reach the latch.
  always_comb begin
    ale = (st_r == EMX_ADDR);
    rd_n = ~((st_r == EMX_STB) && !wr_r);
    wr_n = ~((st_r == EMX_STB) && wr_r);
    addr_hi = addr_r[AW-1:8];
    ad_oe = 1'b0;
    if (st_r == EMX_ADDR && muxed_r) begin
      ad_oe = 1'b1;
    end else if ((st_r == EMX_SETUP || st_r == EMX_STB || st_r == EMX_DONE) && wr_r) begin
      ad_oe = 1'b1;
    end
  end

  // Data pins are flops; decoding the next state keeps them in step with the strobes
  always_comb begin
    addr_lo_nxt = muxed_nxt ? 8'h00 : addr_nxt[7:0];
    ad_out_nxt = wd_nxt;
    if (st_nxt == EMX_ADDR && muxed_nxt) begin
      ad_out_nxt = addr_nxt[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ad_out_r <= DATA_RESET;
      addr_lo_r <= '0;
    end else begin
      ad_out_r <= ad_out_nxt;
      addr_lo_r <= addr_lo_nxt;
    end
  end

  assign ad_out = ad_out_r;
  assign addr_lo = addr_lo_r;

  assign rsp_valid = (st_r == EMX_DONE);
  assign rsp_rdata = rd_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_addr_phase;
    ale && ad_oe && ad_out == addr_r[7:0];
  endsequence

  sequence s_data_phase;
    !ale ##1 !ale;
  endsequence

  property p_mode_sel;
    @(posedge clk_sys) disable iff (rst)
      (req_valid && req_ready) |=> ale == !$past(ext_mem_config_reg[MUX_MODE_BIT_POS]);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode bit ignored");

  property p_ale_len;
    @(posedge clk_sys) disable iff (rst)
      $rose(ale) |-> ale[*2] ##1 !ale;
  endproperty
  a_ale_len: assert property (p_ale_len) else $error("ale width wrong");

  property p_addr_phase;
    @(posedge clk_sys) disable iff (rst)
      ale |-> s_addr_phase;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("low address missing");

  property p_ale_before_strobe;
    @(posedge clk_sys) disable iff (rst)
      $fell(ale) |-> s_data_phase ##0 (!rd_n || !wr_n);
  endproperty
  a_ale_before_strobe: assert property (p_ale_before_strobe) else $error("strobe timing");

  property p_no_overlap;
    @(posedge clk_sys) disable iff (rst)
      ale |-> rd_n && wr_n;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("strobe during ale");

  property p_wr_data;
    @(posedge clk_sys) disable iff (rst)
      !wr_n |-> ad_oe && ad_out == wd_r;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data absent");

  property p_rd_float;
    @(posedge clk_sys) disable iff (rst)
      !rd_n |-> !ad_oe;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("bus driven in read");

  property p_hi_stable;
    @(posedge clk_sys) disable iff (rst)
      (!req_ready && !rsp_valid) |=> $stable(addr_hi) || req_ready;
  endproperty
  a_hi_stable: assert property (p_hi_stable) else $error("upper address moved");

  property p_done_len;
    @(posedge clk_sys) disable iff (rst)
      $rose(ale) |-> ##5 rsp_valid;
  endproperty
  a_done_len: assert property (p_done_len) else $error("access length wrong");
endmodule : emx_mux_if

// *** verilog/emx_pkg.sv ***
package emx_pkg;

  // ------------------------------------------------------------
  // Configuration layout
  // ------------------------------------------------------------
  localparam int MUX_MODE_BIT_POS = 4;
  localparam int CFG_W = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ------------------------------------------------------------
  // Bus widths and phase lengths (system clock cycles)
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ALE_CYC = 2;
  localparam int STB_CYC = 2;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    EMX_IDLE = 3'b000,
    EMX_ADDR = 3'b001,
    EMX_SETUP = 3'b011,
    EMX_STB = 3'b010,
    EMX_DONE = 3'b110
  } emx_state_t;

endpackage : emx_pkg

// *** verilog/emx_cnt.sv ***
`timescale 1ns/1ps
module emx_cnt #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic zero
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign zero = (cnt_r == '0);
endmodule : emx_cnt

// *** tb/emx_mem_model.sv ***
`timescale 1ns/1ps
module emx_mem_model (
  input wire logic clk_sys,
  input wire logic nonmux,
  input wire logic ale,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] addr_lo,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] ad_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat;
  logic [15:0] a;
  // Follows while the strobe is high, frozen from its fall
  always_latch begin
    if (ale) begin
      lat <= ad_out;
    end
  end
  assign a = {addr_hi, nonmux ? addr_lo : lat};
  // Released pins show inverted data so a stale sample cannot pass
  assign ad_in = rd_n ? ~mem[a] : mem[a];
  always @(posedge clk_sys) begin
    if (!wr_n) begin
      mem[a] <= ad_out;
    end
  end
endmodule : emx_mem_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import emx_pkg::*;
  logic clk_sys, rst, req_valid, req_ready, req_write, rsp_valid;
  logic ad_oe, ale, rd_n, wr_n;
  logic [7:0] cfg, req_wdata, rsp_rdata, ad_in, ad_out, addr_hi, addr_lo;
  logic [15:0] req_addr;
  int n_fail, checked, cyc;
  emx_mux_if dut (.clk_sys(clk_sys), .rst(rst), .ext_mem_config_reg(cfg),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .addr_hi(addr_hi), .addr_lo(addr_lo), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
  emx_mem_model mem (.clk_sys(clk_sys), .nonmux(cfg[4]), .ale(ale),
    .ad_out(ad_out), .addr_hi(addr_hi), .addr_lo(addr_lo), .rd_n(rd_n),
    .wr_n(wr_n), .ad_in(ad_in));
  task cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // One access, judged cycle by cycle from the pins
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic nm);
    int n, al;
    n = 0;
    al = 0;
    @(posedge clk_sys);
    cfg <= {3'h0, nm, 4'h0};
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(negedge clk_sys);
    cmp({7'h00, req_ready}, 8'h01);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
      cmp(addr_hi, a[15:8]);
      if (ale === 1'b1) begin
        al++;
        cmp(ad_out, a[7:0]);
        cmp({7'h00, ad_oe}, 8'h01);
      end
      if (wr_n === 1'b0) begin
        cmp(ad_out, d);
      end
      if (nm && (wr_n === 1'b0 || rd_n === 1'b0)) begin
        cmp(addr_lo, a[7:0]);
      end
    end
    cmp({7'h00, rsp_valid}, 8'h01);
    cmp(8'(n), 8'((nm ? 0 : ALE_CYC) + STB_CYC + 2));
    cmp(8'(al), nm ? 8'h00 : 8'(ALE_CYC));
    if (!w) begin
      cmp(rsp_rdata, d);
    end
  endtask : acc
  task t_reset;
    @(negedge clk_sys);
    cmp({2'h0, req_ready, rsp_valid, ale, rd_n, wr_n, ad_oe}, 8'h26);
    $display("test reset done");
  endtask : t_reset
  task t_mux;
    acc(1'b1, 16'h12A5, 8'h3C, 1'b0);
    acc(1'b1, 16'h125A, 8'hC3, 1'b0);
    acc(1'b0, 16'h12A5, 8'h3C, 1'b0);
    acc(1'b0, 16'h125A, 8'hC3, 1'b0);
    $display("test mux done");
  endtask : t_mux
  task t_nonmux;
    acc(1'b1, 16'hFE01, 8'h96, 1'b1);
    acc(1'b0, 16'hFE01, 8'h96, 1'b1);
    acc(1'b0, 16'h125A, 8'hC3, 1'b0);
    $display("test nonmux done");
  endtask : t_nonmux
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    n_fail = 0;
    checked = 0;
    rst = 1'b1;
    cfg = 8'h00;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_mux();
    t_nonmux();
    give_verdict();
  end
endmodule : tb_top
